/* File: sae_pkg.sv */
// Constants and types for the analog enable and pump current register bank
// Contract
// (RULE_01) Bit 0 gates main bias, resets one
// (RULE_02) Bits 1-4 enable pump, comparator, buffers
// (RULE_03) Bit 5 clear keeps output pad undriven
// (RULE_04) Bit 5 and output mode: pad always driven
// (RULE_05) Otherwise pad off on foreign chip address
// (RULE_06) Bit 10 enables oscillator buffer/prescaler bias
// (RULE_07) Host writes bits 18:11 with 55
// (RULE_08) Host sets bit 19 at feedback >=4000MHz
// (RULE_09) Host sets bit 21 for 200-350MHz reference
// (RULE_10) Host keeps other reserved fields at defaults
// (RULE_11) Bits 6:0 pump down code, reset 100
// (RULE_12) Bits 13:7 pump up code, reset 100
// (RULE_13) Bits 20:14 pump offset code, reset zero
// (RULE_14) Host sets offset down bit in fractional
// (RULE_15) Pump register resets to default, bit23 zero
// (RULE_16) Fields act after full write; readback last
package sae_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 24;
  localparam int CODE_W = 7;

  localparam logic [4:0] ANALOG_EN_OFS = 5'h08;
  localparam logic [4:0] PUMP_CUR_OFS = 5'h09;

  localparam logic [23:0] ANALOG_EN_RST = 24'hc1_beff;
  localparam logic [23:0] PUMP_CUR_RST = 24'h40_3264;

  localparam int BIAS_BIT = 0;
  localparam int PUMP_BIT = 1;
  localparam int PHASE_BIT = 2;
  localparam int REFBUF_BIT = 3;
  localparam int OSCBUF_BIT = 4;
  localparam int PAD_BIT = 5;
  localparam int OSC_BIAS_BIT = 10;
  localparam int HALVE_BIT = 19;
  localparam int HIREF_BIT = 21;

  localparam int DOWN_LSB = 0;
  localparam int UP_LSB = 7;
  localparam int OFFSET_LSB = 14;
  localparam int OFS_UP_BIT = 21;
  localparam int OFS_DOWN_BIT = 22;

  // One completed serial write, as handed over by the serial front end
  typedef struct packed {
    logic valid;
    logic [4:0] addr;
    logic [23:0] data;
  } sae_wr_s;

  // Serial transaction status used to release the shared output pad
  typedef struct packed {
    logic active;
    logic addr_match;
  } sae_xfer_s;
endpackage

/* File: sae_regs.sv */
// Analog enable and pump current registers with shared output pad control
module sae_regs (
  input wire logic clk,
  input wire logic srst,
  input wire sae_pkg::sae_wr_s wr_req,
  input wire logic rd_valid,
  input wire logic [4:0] rd_addr,
  input wire sae_pkg::sae_xfer_s xfer,
  input wire logic general_output_port_mode,
  input wire logic pad_data,
  output logic [23:0] rd_data,
  output logic rd_hit,
  output logic bias_on,
  output logic pump_on,
  output logic phase_compare_on,
  output logic reference_buffer_on,
  output logic oscillator_buffer_on,
  output logic lock_out_pad_on,
  output logic osc_prescaler_bias_on,
  output logic feedback_halve_on,
  output logic high_ref_range,
  output logic [6:0] pump_down_code,
  output logic [6:0] pump_up_code,
  output logic [6:0] pump_offset_code,
  output logic pump_offset_up_on,
  output logic pump_offset_down_on,
  output logic lock_or_serial_out_pad_o,
  output logic lock_or_serial_out_pad_oe_n
);

  logic [23:0] analog_block_enables_r;
  logic [23:0] pump_current_control_r;
  logic pad_drive_nxt;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  // Whole-word update on the completed write only, so no field changes mid-transfer
  always_ff @(posedge clk) begin
    if (srst) begin
      analog_block_enables_r <= sae_pkg::ANALOG_EN_RST; // RULE_01 RULE_02 RULE_06
    end else if (wr_req.valid && hit(wr_req.addr, sae_pkg::ANALOG_EN_OFS)) begin
      analog_block_enables_r <= wr_req.data; // RULE_16
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pump_current_control_r <= sae_pkg::PUMP_CUR_RST; // RULE_15
    end else if (wr_req.valid && hit(wr_req.addr, sae_pkg::PUMP_CUR_OFS)) begin
      pump_current_control_r <= wr_req.data; // RULE_16
    end
  end

  // Outputs are the stored bits themselves, so they are flop outputs by construction
  assign bias_on = analog_block_enables_r[sae_pkg::BIAS_BIT]; // RULE_01
  assign pump_on = analog_block_enables_r[sae_pkg::PUMP_BIT]; // RULE_02
  assign phase_compare_on = analog_block_enables_r[sae_pkg::PHASE_BIT]; // RULE_02
  assign reference_buffer_on = analog_block_enables_r[sae_pkg::REFBUF_BIT]; // RULE_02
  assign oscillator_buffer_on = analog_block_enables_r[sae_pkg::OSCBUF_BIT]; // RULE_02
  assign lock_out_pad_on = analog_block_enables_r[sae_pkg::PAD_BIT];
  assign osc_prescaler_bias_on = analog_block_enables_r[sae_pkg::OSC_BIAS_BIT]; // RULE_06
  assign feedback_halve_on = analog_block_enables_r[sae_pkg::HALVE_BIT];
  assign high_ref_range = analog_block_enables_r[sae_pkg::HIREF_BIT];
  assign pump_down_code = pump_current_control_r[sae_pkg::DOWN_LSB +: sae_pkg::CODE_W]; // RULE_11
  assign pump_up_code = pump_current_control_r[sae_pkg::UP_LSB +: sae_pkg::CODE_W]; // RULE_12
  assign pump_offset_code = pump_current_control_r[sae_pkg::OFFSET_LSB +: sae_pkg::CODE_W]; // RULE_13
  assign pump_offset_up_on = pump_current_control_r[sae_pkg::OFS_UP_BIT];
  assign pump_offset_down_on = pump_current_control_r[sae_pkg::OFS_DOWN_BIT];

  // Pad drive decision; outside output mode, a foreign chip address releases the pad so another part may answer
  always_comb begin
    if (!lock_out_pad_on) begin
      pad_drive_nxt = 1'b0; // RULE_03
    end else if (general_output_port_mode) begin
      pad_drive_nxt = 1'b1; // RULE_04
    end else begin
      pad_drive_nxt = !(xfer.active && !xfer.addr_match); // RULE_05
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lock_or_serial_out_pad_oe_n <= 1'b1;
      lock_or_serial_out_pad_o <= 1'b0;
    end else begin
      lock_or_serial_out_pad_oe_n <= !pad_drive_nxt; // RULE_03 RULE_04 RULE_05
      lock_or_serial_out_pad_o <= pad_drive_nxt & pad_data;
    end
  end

  // Readback; unmapped addresses answer zero with rd_hit low
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= 24'h00_0000;
      rd_hit <= 1'b0;
    end else if (rd_valid && hit(rd_addr, sae_pkg::ANALOG_EN_OFS)) begin
      rd_data <= analog_block_enables_r; // RULE_16
      rd_hit <= 1'b1;
    end else if (rd_valid && hit(rd_addr, sae_pkg::PUMP_CUR_OFS)) begin
      rd_data <= pump_current_control_r; // RULE_16
      rd_hit <= 1'b1;
    end else begin
      rd_data <= 24'h00_0000;
      rd_hit <= 1'b0;
    end
  end

  logic wr_an;
  logic wr_pc;
  assign wr_an = wr_req.valid && hit(wr_req.addr, sae_pkg::ANALOG_EN_OFS);
  assign wr_pc = wr_req.valid && hit(wr_req.addr, sae_pkg::PUMP_CUR_OFS);

  a_bias_follow: assert property (@(posedge clk) disable iff (srst)
    wr_an |=> bias_on == $past(wr_req.data[0])) else $error("bias enable not updated"); // RULE_01
  a_path_enables: assert property (@(posedge clk) disable iff (srst)
    wr_an |=> {oscillator_buffer_on, reference_buffer_on, phase_compare_on, pump_on} == $past(wr_req.data[4:1]))
    else $error("path enables not updated"); // RULE_02
  a_pad_off: assert property (@(posedge clk) disable iff (srst)
    !lock_out_pad_on |=> lock_or_serial_out_pad_oe_n) else $error("pad driven while disabled"); // RULE_03
  a_pad_gpo: assert property (@(posedge clk) disable iff (srst)
    lock_out_pad_on && general_output_port_mode |=> !lock_or_serial_out_pad_oe_n)
    else $error("pad not driven in output mode"); // RULE_04
  a_pad_share: assert property (@(posedge clk) disable iff (srst)
    lock_out_pad_on && !general_output_port_mode && xfer.active && !xfer.addr_match |=> lock_or_serial_out_pad_oe_n)
    else $error("pad driven on foreign address"); // RULE_05
  a_osc_bias: assert property (@(posedge clk) disable iff (srst)
    wr_an |=> osc_prescaler_bias_on == $past(wr_req.data[10])) else $error("osc bias not updated"); // RULE_06
  a_down_code: assert property (@(posedge clk) disable iff (srst)
    wr_pc |=> pump_down_code == $past(wr_req.data[6:0])) else $error("down code not updated"); // RULE_11
  a_up_code: assert property (@(posedge clk) disable iff (srst)
    wr_pc |=> pump_up_code == $past(wr_req.data[13:7])) else $error("up code not updated"); // RULE_12
  a_offset_code: assert property (@(posedge clk) disable iff (srst)
    wr_pc |=> pump_offset_code == $past(wr_req.data[20:14])) else $error("offset code not updated"); // RULE_13
  a_pump_reset: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> pump_current_control_r == sae_pkg::PUMP_CUR_RST &&
    analog_block_enables_r == sae_pkg::ANALOG_EN_RST)
    else $error("reset value wrong"); // RULE_15
  a_read_back: assert property (@(posedge clk) disable iff (srst)
    wr_pc ##1 (!wr_req.valid)[*3] ##1 (rd_valid && rd_addr == sae_pkg::PUMP_CUR_OFS && !wr_req.valid)
    |=> rd_data == $past(wr_req.data, 5))
    else $error("readback differs from last write"); // RULE_16
  a_pad_enable_bit: assert property (@(posedge clk) disable iff (srst)
    wr_an |=> lock_out_pad_on == $past(wr_req.data[5])) else $error("pad enable bit not updated"); // RULE_03
  a_pad_quiet: assert property (@(posedge clk) disable iff (srst)
    lock_or_serial_out_pad_oe_n |-> !lock_or_serial_out_pad_o) else $error("pad value while released"); // RULE_03
  a_pad_value: assert property (@(posedge clk) disable iff (srst)
    lock_out_pad_on && general_output_port_mode |=> lock_or_serial_out_pad_o == $past(pad_data))
    else $error("pad value not passed in output mode"); // RULE_04
  // With bit 5 set outside output mode, own or idle traffic keeps the pad driven; only a foreign address releases it
  a_pad_own: assert property (@(posedge clk) disable iff (srst)
    lock_out_pad_on && !general_output_port_mode && !(xfer.active && !xfer.addr_match) |=> !lock_or_serial_out_pad_oe_n)
    else $error("pad released without foreign address"); // RULE_05
  a_write_other: assert property (@(posedge clk) disable iff (srst)
    wr_req.valid && !wr_an && !wr_pc |=> $stable(analog_block_enables_r) && $stable(pump_current_control_r))
    else $error("write to other address changed a register"); // RULE_16
  a_read_miss: assert property (@(posedge clk) disable iff (srst)
    rd_valid && !hit(rd_addr, sae_pkg::ANALOG_EN_OFS) && !hit(rd_addr, sae_pkg::PUMP_CUR_OFS)
    |=> !rd_hit && rd_data == 24'h00_0000) else $error("unmapped read answered"); // RULE_16

  c_pad_release: cover property (@(posedge clk) disable iff (srst)
    !lock_or_serial_out_pad_oe_n ##1 lock_or_serial_out_pad_oe_n);
  c_pump_write: cover property (@(posedge clk) disable iff (srst)
    wr_pc ##4 rd_valid && rd_addr == sae_pkg::PUMP_CUR_OFS);
  c_pad_share: cover property (@(posedge clk) disable iff (srst)
    lock_out_pad_on && !general_output_port_mode && xfer.active && !xfer.addr_match);
  c_pad_gpo: cover property (@(posedge clk) disable iff (srst) lock_out_pad_on && general_output_port_mode);
endmodule

/* File: sae_host.sv */
// Host model handing completed serial writes to the register bank
module sae_host (
  input wire logic clk,
  output sae_pkg::sae_wr_s wr_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial wr_req = '0;
  // Reserved fields of the 5'h08 register are forced, so random data never reaches them
  task automatic write(input logic [4:0] a, input logic [23:0] d);
    logic [23:0] v;
    v = d;
    if (a == 5'h08) begin
      v[18:11] = 8'h37;
      v[9:6] = 4'hb;
      v[23:22] = 2'h3;
      v[20] = 1'b0;
    end
    // Bits 19 and 21 follow the frequency plan; random covers both values
    @(posedge clk);
    wr_req <= '{1'b1, a, v};
    @(posedge clk);
    wr_req.valid <= 1'b0;
  endtask
endmodule

/* File: synth_analog_enable_and_pump_regs_test.sv */
// Self-checking bench for the analog enable and pump current registers
module synth_analog_enable_and_pump_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, rd_valid = 0, mode = 0, pad_data = 0;
  logic [4:0] rd_addr = 5'h00;
  sae_pkg::sae_xfer_s xfer = '0;
  sae_pkg::sae_wr_s wr_req;
  logic [23:0] rd_data, d, ea, ep;
  logic rd_hit, b0, b1, b2, b3, b4, b5, b10, b19, b21, oup, odn, po, oe_n;
  logic [6:0] dn, up, ofs;
  int err_total = 0, samples_checked = 0, seed = 68;
  always #2.5 clk = ~clk;
  sae_host host (.clk(clk), .wr_req(wr_req));
  sae_regs uut (.clk(clk), .srst(srst), .wr_req(wr_req), .rd_valid(rd_valid), .rd_addr(rd_addr), .xfer(xfer),
    .general_output_port_mode(mode), .pad_data(pad_data), .rd_data(rd_data), .rd_hit(rd_hit), .bias_on(b0),
    .pump_on(b1), .phase_compare_on(b2), .reference_buffer_on(b3), .oscillator_buffer_on(b4),
    .lock_out_pad_on(b5), .osc_prescaler_bias_on(b10), .feedback_halve_on(b19), .high_ref_range(b21),
    .pump_down_code(dn), .pump_up_code(up), .pump_offset_code(ofs), .pump_offset_up_on(oup),
    .pump_offset_down_on(odn), .lock_or_serial_out_pad_o(po), .lock_or_serial_out_pad_oe_n(oe_n));
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic fields(input logic [23:0] a, input logic [23:0] p);
    chk("analog", {15'h0000, a[21], a[19], a[10], a[5:0]}, {15'h0000, b21, b19, b10, b5, b4, b3, b2, b1, b0});
    chk("pump", {1'b0, p[22:0]}, {1'b0, odn, oup, ofs, up, dn});
  endtask
  task automatic rd(input logic [4:0] a, input logic [23:0] e, input logic h);
    @(posedge clk);
    rd_valid <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_valid <= 1'b0;
    #1;
    chk("rd_data", e, rd_data);
    chk("rd_hit", {23'h00_0000, h}, {23'h00_0000, rd_hit});
  endtask
  // Active-low pad enable (oe_n) expected from {pad bit, output mode, active, match}
  function automatic logic oe_exp(input logic [3:0] c);
    return !c[3] ? 1'b1 : c[2] ? 1'b0 : (c[1] && !c[0]);
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    fields(24'hc1_beff, 24'h40_3264);
    chk("pad_oe_n", 24'h00_0001, {23'h00_0000, oe_n});
    rd(5'h08, 24'hc1_beff, 1'b1);
    rd(5'h09, 24'h40_3264, 1'b1);
    $display("reset test done");
    ea = 24'hc1_beff;
    ep = 24'h40_3264;
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 24'hff_ffff : (i == 1) ? 24'h00_0000 : $random(seed);
      if (i < 2 || $random(seed) & 1) begin
        host.write(5'h09, d);
        ep = d;
      end else begin
        host.write(5'h08, d);
        ea = {2'h3, d[21], 1'b0, d[19], 8'h37, d[10], 4'hb, d[5:0]};
      end
      #1;
      fields(ea, ep);
      rd(5'h08, ea, 1'b1);
      rd(5'h09, ep, 1'b1);
    end
    host.write(5'h0a, 24'hff_ffff);
    rd(5'h0a, 24'h00_0000, 1'b0);
    rd(5'h09, ep, 1'b1);
    $display("write test done");
    for (int c = 0; c < 16; c++) begin
      host.write(5'h08, {18'h0_0000, c[3], 5'h1f});
      @(posedge clk);
      mode <= c[2];
      xfer <= '{c[1], c[0]};
      pad_data <= $random(seed);
      @(posedge clk);
      #1;
      chk("pad_oe_n", {23'h00_0000, oe_exp(c[3:0])}, {23'h00_0000, oe_n});
      chk("pad_o", {23'h00_0000, !oe_exp(c[3:0]) && pad_data}, {23'h00_0000, po});
    end
    $display("pad test done");
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    fields(24'hc1_beff, 24'h40_3264);
    chk("pad_oe_n", 24'h00_0001, {23'h00_0000, oe_n});
    chk("pad_o", 24'h00_0000, {23'h00_0000, po});
    rd(5'h09, 24'h40_3264, 1'b1);
    rd(5'h08, 24'hc1_beff, 1'b1);
    $display("second reset test done");
    give_verdict();
  end
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule
